// ==== verilog/shp_serial_host_port.sv ====
// How it works
// - read data bit is on the output before the host's first rising edge.
// - the last delay-word edge presents the first bit of the next word.
// - split read: chip select rises after command, falls again for data.
// - any gap length between split command and data phase is accepted.
// - with status enabled a status word follows every transaction.
// - status disable removes the word with no added clocks.
// - 32-bit command, 16-bit data words, optional 32-bit status on output.
// - status bit 0 flags requested read data not available.
// - bit 1 flags read underflow, bit 2 flags write overflow.
// - bits 3,4 channel interrupts, 5,6 receive ready, 7 reserved.
// - bit 8 primary packet ready, bits 9 to 19 its length.
// - bit 20 secondary packet ready, bits 21 to 31 its length.
// - host writes wake bit; device requests oscillator and PLL start.
// - once clocks run after wake, device raises an awake interrupt.
// - interrupt line asserts whenever information is pending, unless a transaction is open with status on and bit 1 of 0x0002 clear.
// - status enable is bit 0 of register 0x0002, reset 1.
// - read delay in register 0x0001, units of 8 bits, reset 4.
// - bit 1 of register 0x0002 allows interrupt while status is sent.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module shp_serial_host_port
  import shp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  output logic miso,
  output logic host_interrupt_line,
  output logic clk_request,
  input wire logic clocks_ready,
  input wire shp_chan_s chan,
  input wire logic [15:0] rd_data,
  input wire logic rd_avail,
  output logic rd_take,
  output logic [15:0] wr_data,
  output logic [1:0] wr_fn,
  output logic wr_valid,
  input wire logic [7:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [31:0] cpu_rdata
);

  logic [2:0] pin_raw;
  logic [2:0] filt;
  logic [2:0] filt_prev_reg;
  shp_state_e st_reg;
  logic [4:0] bit_cnt_reg;
  logic [10:0] word_cnt_reg;
  logic [10:0] dly_cnt_reg;
  logic [31:0] in_sh_reg;
  logic [31:0] tx_sh_reg;
  logic miso_reg;
  shp_cmd_s cmd_reg;
  logic [16:0] addr_reg;
  logic txn_dna_reg;
  logic txn_udf_reg;
  logic txn_ovf_reg;
  logic last_udf_reg;
  logic last_ovf_reg;
  logic [31:0] last_status_reg;
  logic [15:0] wr_data_reg;
  logic [1:0] wr_fn_reg;
  logic wr_valid_reg;
  logic rd_take_reg;
  logic [7:0] r0_reg;
  logic [7:0] r1_reg;
  logic [7:0] r2_reg;
  logic dna_reg;
  logic bp_int_reg;
  logic awake_reg;
  logic wake_rdy_prev_reg;
  logic host_int_reg;
  logic [31:0] cpu_rdata_reg;

  assign pin_raw = {mosi_pin, sclk_pin, cs_n_pin};

  // Three-stage sync; a change counts once stages two and three agree
  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      logic [SYNC_STAGES-1:0] sh_reg;
      logic f_reg;
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sh_reg <= {SYNC_STAGES{FILT_RST[g]}};
          f_reg <= FILT_RST[g];
        end else begin
          sh_reg <= {sh_reg[SYNC_STAGES-2:0], pin_raw[g]};
          if (sh_reg[2] == sh_reg[1]) begin
            f_reg <= sh_reg[2];
          end
        end
      end
      assign filt[g] = f_reg;
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      filt_prev_reg <= FILT_RST;
    end else begin
      filt_prev_reg <= filt;
    end
  end

  wire cs_high = filt[PIN_CS];
  wire mosi_f = filt[PIN_MOSI];
  wire sclk_rise = filt[PIN_SCLK] & ~filt_prev_reg[PIN_SCLK];
  wire cs_fall = ~filt[PIN_CS] & filt_prev_reg[PIN_CS];

  // Transaction decode
  // msb first
  wire shp_cmd_s cmd_next = shp_cmd_s'({in_sh_reg[30:0], mosi_f});
  wire [15:0] data_word = {in_sh_reg[14:0], mosi_f};
  wire [10:0] dly_bits = {r1_reg, 3'h0};
  wire dly_any = r1_reg != 8'h00;
  // delay on backplane reads unless applied to all
  wire use_dly_n = dly_any && (cmd_next.fn == FN_BP || r2_reg[R2_DLY_ALL]);
  wire use_dly = dly_any && (cmd_reg.fn == FN_BP || r2_reg[R2_DLY_ALL]);
  wire [10:0] len_words = {1'b0, cmd_next.len[10:1]} + {10'h000, cmd_next.len[0]};
  wire [10:0] words_n = (len_words == 11'h000) ? MAX_WORDS : len_words;
  wire stat_en = r2_reg[R2_STAT_EN];

  wire in_cmd = sclk_rise && st_reg == ST_CMD;
  wire cmd_end = in_cmd && bit_cnt_reg == CMD_LAST_BIT;
  wire in_data = sclk_rise && st_reg == ST_DATA;
  wire word_end = in_data && bit_cnt_reg == WORD_LAST_BIT;
  wire last_word = word_cnt_reg == 11'h001;
  wire dly_end = sclk_rise && st_reg == ST_DLY && dly_cnt_reg == 11'h001;
  wire gap_start = st_reg == ST_GAP && cs_fall;

  // fetch at the edge that closes the command, delay or a non-final data word
  wire load_a = cmd_end && !cmd_next.wr && !use_dly_n;
  wire load_c = word_end && !cmd_reg.wr && !last_word;
  wire rd_load = load_a || dly_end || load_c;
  wire [1:0] fetch_fn = cmd_end ? cmd_next.fn : cmd_reg.fn;
  wire [16:0] fetch_addr = cmd_end ? cmd_next.addr : addr_reg;
  wire fetch_ext = rd_load && fetch_fn != FN_STD;
  wire dna_evt = fetch_ext && !rd_avail;
  wire std_wr = word_end && cmd_reg.wr && cmd_reg.fn == FN_STD;
  wire addr_step = rd_load || (word_end && cmd_reg.wr);
  wire [16:0] addr_base = cmd_end ? cmd_next.addr : addr_reg;

  wire [7:0] r4_val = {2'h0, chan.sec_avail, chan.pri_avail, 1'b0,
                       last_ovf_reg, last_udf_reg, dna_reg};
  wire [7:0] r5_val = {chan.sec_int, chan.pri_int | awake_reg, bp_int_reg, 5'h00};

  function automatic logic [15:0] std_word(input logic [1:0] idx);
    if (idx == IDX_CFG01) begin
      std_word = {r1_reg, r0_reg};
    end else if (idx == IDX_CFG23) begin
      std_word = {8'h00, r2_reg};
    end else if (idx == IDX_INT45) begin
      std_word = {r5_val, r4_val};
    end else begin
      std_word = 16'h0000;
    end
  endfunction : std_word

  wire [15:0] ext_word = rd_avail ? rd_data : 16'h0000;
  wire [15:0] fetch_word = (fetch_fn == FN_STD) ? std_word(fetch_addr[2:1]) : ext_word;

  // underflow and overflow include this cycle's report
  wire shp_status_s stat_word = '{
    sec_len: chan.sec_len,
    sec_avail: chan.sec_avail,
    pri_len: chan.pri_len,
    pri_avail: chan.pri_avail,
    rsvd: 1'b0,
    sec_rx_rdy: chan.sec_rx_rdy,
    pri_rx_rdy: chan.pri_rx_rdy,
    sec_int: chan.sec_int,
    pri_int: chan.pri_int,
    ovf: txn_ovf_reg | chan.ovf,
    udf: txn_udf_reg | chan.udf,
    dna: txn_dna_reg
  };
  wire stat_load = word_end && last_word && stat_en;
  wire [31:0] stat_bits = stat_word;
  // fetched read word, else status word, on the output line
  wire [31:0] load_word = rd_load ? {fetch_word, 16'h0000} : stat_bits;
  wire split_load = rd_load && cmd_end && cmd_next.split;
  wire tx_step = (sclk_rise && st_reg != ST_GAP) || gap_start;

  // Framing state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      bit_cnt_reg <= 5'h00;
      word_cnt_reg <= 11'h000;
      dly_cnt_reg <= 11'h000;
      cmd_reg <= '0;
    end else if (cs_high && st_reg != ST_GAP) begin
      // chip select high ends the phase
      st_reg <= ST_IDLE;
      bit_cnt_reg <= 5'h00;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          st_reg <= ST_CMD;
          bit_cnt_reg <= 5'h00;
        end
        ST_CMD: begin
          if (cmd_end) begin
            cmd_reg <= cmd_next;
            word_cnt_reg <= words_n;
            dly_cnt_reg <= dly_bits;
            bit_cnt_reg <= 5'h00;
            if (cmd_next.split) begin
              st_reg <= ST_GAP;
            end else if (!cmd_next.wr && use_dly_n) begin
              st_reg <= ST_DLY;
            end else begin
              st_reg <= ST_DATA;
            end
          end else if (in_cmd) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        ST_GAP: begin
          // wait any time for the data phase
          if (gap_start) begin
            st_reg <= use_dly ? ST_DLY : ST_DATA;
            bit_cnt_reg <= 5'h00;
          end
        end
        ST_DLY: begin
          if (dly_end) begin
            st_reg <= ST_DATA;
          end else if (sclk_rise) begin
            dly_cnt_reg <= dly_cnt_reg - 11'h001;
          end
        end
        ST_DATA: begin
          if (word_end) begin
            bit_cnt_reg <= 5'h00;
            word_cnt_reg <= word_cnt_reg - 11'h001;
            // status after the last word; none when disabled
            if (last_word) begin
              st_reg <= stat_en ? ST_STAT : ST_DONE;
            end
          end else if (in_data) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end
        end
        ST_STAT: begin
          if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == STAT_LAST_BIT) begin
              st_reg <= ST_DONE;
            end
          end
        end
        default: begin
          st_reg <= ST_DONE;
        end
      endcase
    end
  end

  // Shifters and output bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_sh_reg <= 32'h0000_0000;
      tx_sh_reg <= 32'h0000_0000;
      miso_reg <= 1'b0;
      addr_reg <= 17'h00000;
    end else begin
      if (sclk_rise) begin
        in_sh_reg <= {in_sh_reg[30:0], mosi_f};
      end
      if (addr_step) begin
        addr_reg <= addr_base + ADDR_STEP;
      end else if (cmd_end) begin
        addr_reg <= cmd_next.addr;
      end
      if (cs_high && st_reg != ST_GAP) begin
        tx_sh_reg <= 32'h0000_0000;
        miso_reg <= 1'b0;
      end else if (split_load) begin
        // split data waits for the second phase
        tx_sh_reg <= {fetch_word, 16'h0000};
      end else if (rd_load || stat_load) begin
        // bit stands from this edge to the next rise
        miso_reg <= load_word[31];
        tx_sh_reg <= {load_word[30:0], 1'b0};
      end else if (tx_step) begin
        miso_reg <= tx_sh_reg[31];
        tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
      end
    end
  end

  // Per-transaction error flags and user-side strobes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txn_dna_reg <= 1'b0;
      txn_udf_reg <= 1'b0;
      txn_ovf_reg <= 1'b0;
      last_udf_reg <= 1'b0;
      last_ovf_reg <= 1'b0;
      last_status_reg <= 32'h0000_0000;
      wr_data_reg <= 16'h0000;
      wr_fn_reg <= FN_STD;
      wr_valid_reg <= 1'b0;
      rd_take_reg <= 1'b0;
    end else begin
      wr_valid_reg <= word_end && cmd_reg.wr && cmd_reg.fn != FN_STD;
      rd_take_reg <= fetch_ext && rd_avail;
      if (word_end && cmd_reg.wr) begin
        wr_data_reg <= data_word;
        wr_fn_reg <= cmd_reg.fn;
      end
      if (st_reg == ST_IDLE && !cs_high) begin
        txn_dna_reg <= 1'b0;
        txn_udf_reg <= 1'b0;
        txn_ovf_reg <= 1'b0;
      end else begin
        txn_dna_reg <= txn_dna_reg | dna_evt;
        txn_udf_reg <= txn_udf_reg | chan.udf;
        txn_ovf_reg <= txn_ovf_reg | chan.ovf;
      end
      if (word_end && last_word) begin
        last_udf_reg <= txn_udf_reg | chan.udf;
        last_ovf_reg <= txn_ovf_reg | chan.ovf;
        last_status_reg <= stat_word;
      end
    end
  end

  // Host-visible registers
  wire [1:0] wr_idx = addr_reg[2:1];
  wire wr_cfg01 = std_wr && wr_idx == IDX_CFG01;
  wire wr_cfg23 = std_wr && wr_idx == IDX_CFG23;
  wire wr_int45 = std_wr && wr_idx == IDX_INT45;
  wire clr_dna = wr_int45 && data_word[R4_DNA];
  wire clr_bp = wr_int45 && data_word[8 + R5_BP_INT];
  wire clr_awake = wr_int45 && data_word[8 + R5_PRI_INT];
  wire cpu_ctrl_wr = cpu_wr && cpu_addr == CPU_CTRL;
  wire set_bp = cpu_ctrl_wr && cpu_wdata[CTRL_BP_INT];
  wire wake_rdy = r0_reg[R0_WAKE] && clocks_ready;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      r0_reg <= R0_RST;
      r1_reg <= R1_RST;
      r2_reg <= R2_RST;
      dna_reg <= 1'b0;
      bp_int_reg <= 1'b0;
      awake_reg <= 1'b0;
      wake_rdy_prev_reg <= 1'b0;
    end else begin
      if (wr_cfg01) begin
        r0_reg <= data_word[7:0] & R0_MASK;
        r1_reg <= data_word[15:8];
      end
      if (wr_cfg23) begin
        r2_reg <= data_word[7:0] & R2_MASK;
      end
      wake_rdy_prev_reg <= wake_rdy;
      // Set wins over host clear
      dna_reg <= dna_evt | (dna_reg & ~clr_dna);
      bp_int_reg <= set_bp | (bp_int_reg & ~clr_bp);
      awake_reg <= (wake_rdy & ~wake_rdy_prev_reg) | (awake_reg & ~clr_awake);
    end
  end

  // any pending information raises the line
  wire pending = dna_reg | bp_int_reg | awake_reg | chan.pri_int | chan.sec_int;
  // hold back while any transaction is open, including a split gap, when status words are enabled and bit 1 of 0x0002 is clear
  wire stat_busy = st_reg != ST_IDLE && stat_en && !r2_reg[R2_INT_W_STAT];
  wire int_act = pending && !stat_busy;

  wire cpu_rd_cfg = cpu_addr == CPU_CFG;
  wire cpu_rd_stat = cpu_addr == CPU_STATUS;
  wire cpu_rd_ctrl = cpu_addr == CPU_CTRL;
  wire [31:0] ctrl_val = {29'h0000_0000, awake_reg, r0_reg[R0_WAKE], bp_int_reg};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_int_reg <= 1'b0;
      cpu_rdata_reg <= 32'h0000_0000;
    end else begin
      host_int_reg <= r0_reg[R0_POL] ? int_act : ~int_act;
      if (!cpu_rd) begin
        cpu_rdata_reg <= 32'h0000_0000;
      end else if (cpu_rd_cfg) begin
        cpu_rdata_reg <= {8'h00, r2_reg, r1_reg, r0_reg};
      end else if (cpu_rd_stat) begin
        cpu_rdata_reg <= last_status_reg;
      end else if (cpu_rd_ctrl) begin
        cpu_rdata_reg <= ctrl_val;
      end else begin
        cpu_rdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign miso = miso_reg;
  assign host_interrupt_line = host_int_reg;
  assign clk_request = r0_reg[R0_WAKE];
  assign rd_take = rd_take_reg;
  assign wr_data = wr_data_reg;
  assign wr_fn = wr_fn_reg;
  assign wr_valid = wr_valid_reg;
  assign cpu_rdata = cpu_rdata_reg;

endmodule : shp_serial_host_port

// ==== verilog/shp_pkg.sv ====
package shp_pkg;

  // Sync chain and filtered pin order: cs_n, sclk, mosi
  localparam int SYNC_STAGES = 3;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_MOSI = 2;
  localparam logic [2:0] FILT_RST = 3'h1;

  localparam logic [4:0] CMD_LAST_BIT = 5'h1F;
  localparam logic [4:0] WORD_LAST_BIT = 5'h0F;
  localparam logic [4:0] STAT_LAST_BIT = 5'h1F;
  localparam logic [10:0] MAX_WORDS = 11'h400;
  localparam logic [16:0] ADDR_STEP = 17'h00002;

  localparam logic [1:0] FN_STD = 2'h0;
  localparam logic [1:0] FN_BP = 2'h1;
  localparam logic [1:0] FN_PRI = 2'h2;
  localparam logic [1:0] FN_SEC = 2'h3;

  // Host-visible configuration bytes
  localparam logic [7:0] R0_RST = 8'h30;
  localparam logic [7:0] R0_MASK = 8'hB3;
  localparam logic [7:0] R1_RST = 8'h04;
  localparam logic [7:0] R2_RST = 8'h01;
  localparam logic [7:0] R2_MASK = 8'h07;
  localparam int R0_POL = 5;
  localparam int R0_WAKE = 7;
  localparam int R2_STAT_EN = 0;
  localparam int R2_INT_W_STAT = 1;
  localparam int R2_DLY_ALL = 2;
  localparam int R4_DNA = 0;
  localparam int R5_BP_INT = 5;
  localparam int R5_PRI_INT = 6;
  localparam logic [1:0] IDX_CFG01 = 2'h0;
  localparam logic [1:0] IDX_CFG23 = 2'h1;
  localparam logic [1:0] IDX_INT45 = 2'h2;

  // Local processor port
  localparam logic [7:0] CPU_CFG = 8'h00;
  localparam logic [7:0] CPU_STATUS = 8'h04;
  localparam logic [7:0] CPU_CTRL = 8'h08;
  localparam int CTRL_BP_INT = 0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_GAP, ST_DLY, ST_DATA, ST_STAT, ST_DONE
  } shp_state_e;

  typedef struct packed {
    logic wr;
    logic split;
    logic [1:0] fn;
    logic [16:0] addr;
    logic [10:0] len;
  } shp_cmd_s;

  typedef struct packed {
    logic [10:0] sec_len;
    logic sec_avail;
    logic [10:0] pri_len;
    logic pri_avail;
    logic rsvd;
    logic sec_rx_rdy;
    logic pri_rx_rdy;
    logic sec_int;
    logic pri_int;
    logic ovf;
    logic udf;
    logic dna;
  } shp_status_s;

  typedef struct packed {
    logic udf;
    logic ovf;
    logic pri_int;
    logic sec_int;
    logic pri_rx_rdy;
    logic sec_rx_rdy;
    logic pri_avail;
    logic [10:0] pri_len;
    logic sec_avail;
    logic [10:0] sec_len;
  } shp_chan_s;

endpackage : shp_pkg

// ==== sim/shp_port_props.sv ====
`timescale 1ns/1ps
module shp_port_props
  import shp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  input wire logic miso,
  input wire logic host_interrupt_line,
  input wire logic clk_request,
  input wire logic clocks_ready,
  input wire shp_chan_s chan,
  input wire logic [15:0] rd_data,
  input wire logic rd_avail,
  input wire logic rd_take,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_fn,
  input wire logic wr_valid,
  input wire logic [7:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [31:0] cpu_rdata
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  miso_idle_a: assert property (cs_n_pin [*6] |-> !miso)
    else $error("miso driven while deselected");
  bit_hold_a: assert property (sclk_pin [*4] |-> $stable(miso))
    else $error("miso moved during clock high phase");
  fetch_avail_a: assert property (rd_take |-> $past(rd_avail))
    else $error("read word taken while unavailable");
  fetch_space_a: assert property (rd_take |=> !rd_take [*8])
    else $error("read words fetched too close");
  write_fn_a: assert property (wr_valid |-> wr_fn != FN_STD && $past(cs_n_pin, 6) == 1'b0)
    else $error("write word outside a transaction");
  wake_hold_a: assert property (cs_n_pin [*8] |-> $stable(clk_request))
    else $error("clock request moved while idle");
  awake_irq_a: assert property ((cs_n_pin [*4] ##0 (clk_request && $rose(clocks_ready)))
    |-> ##[1:4] host_interrupt_line)
    else $error("no awake interrupt");
  ctrl_irq_a: assert property ((cs_n_pin [*4] ##0 (cpu_wr && cpu_addr == CPU_CTRL
    && cpu_wdata[CTRL_BP_INT])) |-> ##[1:3] host_interrupt_line)
    else $error("pending event not signalled");
endmodule : shp_port_props

bind shp_serial_host_port shp_port_props u_props (
  .ref_clk(ref_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
  .mosi_pin(mosi_pin), .miso(miso), .host_interrupt_line(host_interrupt_line),
  .clk_request(clk_request), .clocks_ready(clocks_ready), .chan(chan),
  .rd_data(rd_data), .rd_avail(rd_avail), .rd_take(rd_take), .wr_data(wr_data),
  .wr_fn(wr_fn), .wr_valid(wr_valid), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata)
);

// ==== sim/shp_host_model.sv ====
`timescale 1ns/1ps
module shp_host_model (
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // Odd offset keeps pin edges away from the sampling clock
  task automatic open_frame;
    #207;
    cs_n = 1'b0;
    // Lead time before the first clock of a phase
    #200;
  endtask : open_frame
  task automatic close_frame;
    #200;
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask : close_frame
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #200;
      // Read data taken at the rising edge
      rx = {rx[30:0], miso};
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
    end
  endtask : shift
endmodule : shp_host_model

// ==== sim/shp_serial_host_port_tb.sv ====
`timescale 1ns/1ps
module shp_serial_host_port_tb;
  import shp_pkg::*;
  logic ref_clk, rst, cs_n_pin, sclk_pin, mosi_pin, miso, host_interrupt_line;
  logic clk_request, clocks_ready, rd_avail, rd_take, wr_valid, cpu_wr, cpu_rd;
  logic [15:0] rd_data, wr_data, rd;
  logic [1:0] wr_fn;
  logic [7:0] cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata, st, w;
  shp_chan_s chan;
  int mismatches, samples_checked;
  shp_serial_host_port u_dut (.ref_clk(ref_clk), .rst(rst), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .mosi_pin(mosi_pin), .miso(miso),
    .host_interrupt_line(host_interrupt_line), .clk_request(clk_request),
    .clocks_ready(clocks_ready), .chan(chan), .rd_data(rd_data), .rd_avail(rd_avail),
    .rd_take(rd_take), .wr_data(wr_data), .wr_fn(wr_fn), .wr_valid(wr_valid),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata));
  shp_host_model u_host (.cs_n(cs_n_pin), .sclk(sclk_pin), .mosi(mosi_pin), .miso(miso));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : flag
  task automatic cpu_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask : cpu_write
  task automatic cpu_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    #1;
    d = cpu_rdata;
  endtask : cpu_read
  function automatic shp_cmd_s mk(input logic wr, input logic sp, input logic [1:0] fn,
      input logic [16:0] a);
    return '{wr: wr, split: sp, fn: fn, addr: a, len: 11'h002};
  endfunction : mk
  function automatic logic [31:0] exp_st(input logic dna);
    return {chan.sec_len, chan.sec_avail, chan.pri_len, chan.pri_avail, 1'b0,
      chan.sec_rx_rdy, chan.pri_rx_rdy, chan.sec_int, chan.pri_int, chan.ovf, chan.udf, dna};
  endfunction : exp_st
  task automatic txn(input shp_cmd_s c, input logic [15:0] wd, input int dly, input int gap,
      input bit stat);
    logic [31:0] rx;
    u_host.open_frame();
    u_host.shift(c, 32, rx);
    if (c.split) begin
      u_host.close_frame();
      repeat (gap) @(posedge ref_clk);
      u_host.open_frame();
    end
    if (dly > 0) begin
      u_host.shift(32'h0, dly, rx);
    end
    u_host.shift({16'h0, wd}, 16, rx);
    rd = rx[15:0];
    if (stat) begin
      u_host.shift(32'h0, 32, rx);
      st = rx;
    end
    u_host.close_frame();
    repeat (8) @(posedge ref_clk);
  endtask : txn
  initial begin
    #3_000_000;
    mismatches++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    clocks_ready = 1'b0;
    chan = '0;
    rd_data = 16'h0;
    rd_avail = 1'b0;
    cpu_addr = 8'h0;
    cpu_wdata = 32'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    cpu_read(CPU_CFG, w);
    check(w, 32'h00010430);
    flag(miso | host_interrupt_line | clk_request, 1'b0);
    cpu_read(8'hFC, w);
    check(w, 32'h0);
    txn(mk(1, 0, FN_STD, 17'h0), 16'h04B0, 0, 0, 1);
    check(st, exp_st(0));
    flag(clk_request, 1'b1);
    clocks_ready <= 1'b1;
    repeat (6) @(posedge ref_clk);
    flag(host_interrupt_line, 1'b1);
    txn(mk(0, 0, FN_STD, 17'h4), 16'h0, 0, 0, 1);
    check(rd, 16'h4000);
    txn(mk(1, 0, FN_STD, 17'h4), 16'h4000, 0, 0, 1);
    flag(host_interrupt_line, 1'b0);
    chan <= '{udf: 0, ovf: 1, pri_int: 0, sec_int: 1, pri_rx_rdy: 1, sec_rx_rdy: 0,
      pri_avail: 1, pri_len: 11'h5A3, sec_avail: 1, sec_len: 11'h2C7};
    txn(mk(1, 0, FN_PRI, 17'h0), 16'hC3A5, 0, 0, 1);
    check({wr_fn, wr_data}, {FN_PRI, 16'hC3A5});
    check(st, exp_st(0));
    cpu_read(CPU_STATUS, w);
    check(w, exp_st(0));
    flag(host_interrupt_line, 1'b1);
    chan <= '0;
    rd_data <= 16'h9E61;
    rd_avail <= 1'b1;
    txn(mk(0, 0, FN_BP, 17'h40), 16'h0, 32, 0, 1);
    check(rd, 16'h9E61);
    check(st, exp_st(0));
    rd_avail <= 1'b0;
    txn(mk(0, 0, FN_BP, 17'h40), 16'h0, 32, 0, 1);
    check(st, exp_st(1));
    flag(host_interrupt_line, 1'b1);
    txn(mk(1, 0, FN_STD, 17'h4), 16'h0001, 0, 0, 1);
    flag(host_interrupt_line, 1'b0);
    rd_avail <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      chan.udf <= (i == 0);
      rd_data <= 16'h7BD2 ^ 16'(i);
      txn(mk(1, 0, FN_PRI, 17'h8), 16'h1111, 0, 0, 1);
      txn(mk(0, 1, i ? FN_BP : FN_PRI, 17'h8), 16'h0, i ? 32 : 0, i ? 3 : 61, 1);
      check(rd, 16'h7BD2 ^ 16'(i));
      check(st, exp_st(0));
    end
    chan <= '0;
    txn(mk(1, 0, FN_STD, 17'h2), 16'h0000, 0, 0, 0);
    u_host.open_frame();
    u_host.shift(32'hC0000000, 12, w);
    u_host.close_frame();
    repeat (8) @(posedge ref_clk);
    txn(mk(0, 0, FN_STD, 17'h0), 16'h0, 0, 0, 0);
    check(rd, 16'h04B0);
    cpu_read(CPU_CFG, w);
    check(w, 32'h000004B0);
    cpu_write(CPU_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    flag(host_interrupt_line, 1'b1);
    cpu_read(CPU_CTRL, w);
    check(w, 32'h3);
    txn(mk(1, 0, FN_STD, 17'h4), 16'h2000, 0, 0, 0);
    flag(host_interrupt_line, 1'b0);
    txn(mk(1, 0, FN_STD, 17'h0), 16'h0430, 0, 0, 0);
    flag(clk_request, 1'b0);
    txn(mk(1, 0, FN_STD, 17'h0), 16'h04B0, 0, 0, 0);
    flag(host_interrupt_line, 1'b1);
    print_verdict();
  end
endmodule : shp_serial_host_port_tb
